//--- src/ext_irq_vector_map.v
// Purpose: external request and pin-change interrupt detection plus the
//          fixed mapping of all sources onto program vector addresses
// Assumes: core presents a one-cycle acknowledge when it enters a vector
// Notes:   register port: addr, wdata, write strobe, read strobe, rdata
//          one cycle later, and zero in every other cycle
//          register map by index:
//            0 sense of request 0 in bits 1:0, request 1 in bits 3:2
//            1 enables: 7 request 1, 6 request 0, 5 and 4 pin change
//            2 request flags: 7 request 1, 6 request 0, 5 pin change,
//              each cleared by writing a one
//            3 pin-change mask, low byte
//            4 pin-change mask, high byte
//            5 global enable in bit 0
//            6 sticky status, cleared by writing a one
//            7 mask of the status bits that reach irq
//            8 last clocked pin-change sample, low byte
//            9 last clocked pin-change sample, high byte
//            a pending flag in bit 7, chosen vector in bits 4:0
//          other indices read zero and ignore writes
//          an edge flag sets three clocks after its pad moves: two for
//          the synchroniser and one for the flag itself
//          low level and pin change reach wake_request with no flop in
//          their path, so they still work with the io clock halted
//          either pin-change enable bit arms every masked pin
//
// What this block does
// - every reset restarts at address zero
// - sources map to vectors one to eighteen
// - second vector group at fixed addresses
// - vector fetched only when interrupt taken
// - two request pins, sixteen pin-change inputs
// - pins as outputs still raise requests
// - any masked pin toggle gives one request
// - pin change detected without clock for wake
// - falling, rising or low level per request
// - low level keeps request asserted continuously
// - edges seen only while clock runs
// - sense codes: low, change, fall, rise
// - request 0 low level wakes without clock
`timescale 1ns/100ps
`default_nettype none
`include "ext_irq_regs.vh"

module ext_irq_vector_map #(
  parameter NUM_PC = 16
) (
  // clock and reset
  input  wire              clk_sys,
  input  wire              reset_n,
  // register port
  input  wire [3:0]        reg_addr,
  input  wire [7:0]        reg_wdata,
  input  wire              reg_write,
  input  wire              reg_read,
  output reg  [7:0]        reg_rdata,
  // device pins (sampled pad values, so output pins count too)
  input  wire              ext_request0_pin,
  input  wire              ext_request1_pin,
  input  wire [NUM_PC-1:0] pin_change_inputs,
  // other interrupt sources, vectors 3..12 and 14..18
  input  wire [17:0]       periph_request,
  // core vectoring
  input  wire              core_ack,
  input  wire              io_clock_running,
  output wire              core_irq,
  output wire [4:0]        core_vector,
  output wire [4:0]        reset_vector,
  output wire              wake_request,
  // system interrupt
  output wire              irq
);

  // software setup, request flags and the last clocked samples
  // of the pads
  reg  [7:0]        mcu_control_reg;
  reg  [7:0]        source_enable;
  reg  [NUM_PC-1:0] pin_change_mask;
  reg               global_enable;
  reg  [7:0]        irq_status;
  reg  [7:0]        irq_mask;
  reg               flag_req0;
  reg               flag_req1;
  reg               flag_pc;
  reg  [1:0]        ext_prev;
  reg  [NUM_PC-1:0] pc_prev;

  // synchronised pads and the two decoded sense fields
  wire [1:0]        ext_sync;
  wire [1:0]        ext_sense_select;
  wire [1:0]        ext_sense_select1;
  wire              ext_sense_select_hi;
  wire              ext_sense_select_lo;
  // per-line request paths, then the pending word and the core side
  wire [1:0]        edge_hit;
  wire [1:0]        level_active;
  wire              pc_toggle;
  wire [17:0]       pending;
  wire              any_pending;
  wire [4:0]        best_vector;
  // acknowledge decode and the status event word
  wire              ack_req0;
  wire              ack_req1;
  wire              ack_pc;
  wire [7:0]        events;

  assign ext_sense_select    = mcu_control_reg[`MCR_SENSE0_LO+1:`MCR_SENSE0_LO];
  assign ext_sense_select1   = mcu_control_reg[`MCR_SENSE1_LO+1:`MCR_SENSE1_LO];
  assign ext_sense_select_hi = ext_sense_select[1];
  assign ext_sense_select_lo = ext_sense_select[0];

  // request pins go through two flops before any edge comparison
  // the flops reset high to match the idle level of the pads
  pin_sync #(
    .WIDTH        (2)
  ) u_sync (
    .clk_sys      (clk_sys),
    .reset_n      (reset_n),
    .pin_in       ({ext_request1_pin, ext_request0_pin}),
    .pin_sync_out (ext_sync)
  );

  // previous sample follows the synchroniser on every clock: if it froze
  // while the io clock is halted, a level that moved meanwhile would
  // come out as an edge once the clock runs again
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_prev <= 2'h3;
    end else begin
      ext_prev <= ext_sync;
    end
  end

  // edge decode per request line from its sense field
  // the low-level code gives no edge: that path skips the flops
  function edge_of;
    input [1:0] sense;
    input       now;
    input       prev;
    begin
      case (sense)
        `SENSE_ANY:  edge_of = now ^ prev;
        `SENSE_FALL: edge_of = prev & ~now;
        `SENSE_RISE: edge_of = now & ~prev;
        default:     edge_of = 1'b0;
      endcase
    end
  endfunction

  // both request lines share one decode; each takes its own two-bit
  // sense field and its own pad
  wire [3:0]        sense_pair;
  wire [1:0]        req_pins;

  assign sense_pair = {ext_sense_select1, ext_sense_select};
  assign req_pins   = {ext_request1_pin, ext_request0_pin};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : req_line
      // edges only count while the io clock is present
      assign edge_hit[g] = io_clock_running &
                           edge_of(sense_pair[2*g+1:2*g], ext_sync[g],
                                   ext_prev[g]);
      // low level taken straight off the pad, no clock needed
      assign level_active[g] = (sense_pair[2*g+1:2*g] == `SENSE_LOW) &
                               ~req_pins[g];
    end
  endgenerate

  // pin-change history; compared with the raw pads for the wake path
  // it resets low, so a masked pin already high may flag once
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pc_prev <= {NUM_PC{1'b0}};
    end else begin
      pc_prev <= pin_change_inputs;
    end
  end

  // one combined request from any masked pin that toggled
  assign pc_toggle = |((pin_change_inputs ^ pc_prev) &
                       pin_change_mask);

  // wake path: unclocked pin change or low level, enables honoured
  // global enable is left out on purpose: a wake must not need it
  assign wake_request =
    (pc_toggle & (source_enable[`BIT_PC_HI] |
                  source_enable[`BIT_PC_LO])) |
    (level_active[0] & source_enable[`BIT_REQ0]) |
    (level_active[1] & source_enable[`BIT_REQ1]);

  // acknowledge clears the flag of the vector actually taken
  // a lower pending vector shadows the rest, so only one flag drops
  assign ack_req0 = core_ack & (best_vector == `VEC_REQ0);
  assign ack_req1 = core_ack & (best_vector == `VEC_REQ1);
  assign ack_pc   = core_ack & (best_vector == `VEC_PIN_CHANGE);

  // the core acknowledge and a write of one both clear a flag
  // request flags: a new event wins over a clear in the same cycle;
  // level mode keeps the flag clear since the level drives directly
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flag_req0 <= 1'b0;
      flag_req1 <= 1'b0;
      flag_pc   <= 1'b0;
    end else begin
      if (ext_sense_select == `SENSE_LOW) begin
        flag_req0 <= 1'b0;
      end else if (edge_hit[0]) begin
        flag_req0 <= 1'b1;
      end else if (ack_req0 || (reg_write &&
               reg_addr == `REG_FLAGS && reg_wdata[`BIT_REQ0])) begin
        flag_req0 <= 1'b0;
      end
      if (ext_sense_select1 == `SENSE_LOW) begin
        flag_req1 <= 1'b0;
      end else if (edge_hit[1]) begin
        flag_req1 <= 1'b1;
      end else if (ack_req1 || (reg_write &&
               reg_addr == `REG_FLAGS && reg_wdata[`BIT_REQ1])) begin
        flag_req1 <= 1'b0;
      end
      if (pc_toggle) begin
        flag_pc <= 1'b1;
      end else if (ack_pc || (reg_write &&
               reg_addr == `REG_FLAGS && reg_wdata[`BIT_PCF])) begin
        flag_pc <= 1'b0;
      end
    end
  end

  // pending vector bits, index i is vector address i+1
  // peripheral levels pass straight through; their own blocks gate them
  assign pending[0]  = source_enable[`BIT_REQ0] &
                       (flag_req0 | level_active[0]);
  assign pending[1]  = (source_enable[`BIT_PC_HI] |
                        source_enable[`BIT_PC_LO]) & flag_pc;
  assign pending[11:2]  = periph_request[11:2];
  assign pending[12] = source_enable[`BIT_REQ1] &
                       (flag_req1 | level_active[1]);
  assign pending[17:13] = periph_request[17:13];

  vector_select #(
    .NUM         (`NUM_SOURCES)
  ) u_select (
    .request     (pending),
    .any_request (any_pending),
    .vector_addr (best_vector)
  );

  // core_vector is shown even while no request is forwarded
  // the core only vectors when global enable is on; otherwise the vector
  // table space is never fetched
  assign core_irq     = global_enable & any_pending;
  assign core_vector  = best_vector;
  assign reset_vector = `VEC_RESET;

  // sticky system status: req0, req1, pin change, core vector taken
  // a held low level raises its event bit on every clock, so a clear
  // only sticks once the pin is back high
  assign events = {4'h0, core_ack & core_irq, pc_toggle,
                   edge_hit[1] | level_active[1],
                   edge_hit[0] | level_active[0]};

  // status bits: set wins over the write-one clear
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= 8'h00;
    end else if (reg_write && reg_addr == `REG_IRQ_STATUS) begin
      irq_status <= (irq_status & ~reg_wdata) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // register writes
  // the low nibble of the enables has no source behind it and reads 0
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mcu_control_reg <= `RST_MCU_CONTROL;
      source_enable   <= `RST_ENABLE;
      pin_change_mask <= {`RST_PCMASK_HI, `RST_PCMASK_LO};
      global_enable   <= 1'b0;
      irq_mask        <= `RST_IRQ_MASK;
    end else if (reg_write) begin
      case (reg_addr)
        `REG_MCU_CONTROL:   mcu_control_reg <= reg_wdata;
        `REG_SOURCE_ENABLE: source_enable <= reg_wdata & 8'hf0;
        `REG_PCMASK_LO:     pin_change_mask[7:0] <= reg_wdata;
        `REG_PCMASK_HI:     pin_change_mask[15:8] <= reg_wdata;
        `REG_GLOBAL:        global_enable <= reg_wdata[0];
        `REG_IRQ_MASK:      irq_mask <= reg_wdata;
        default:            global_enable <= global_enable;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  // rdata drops to zero in every other cycle so a late look sees 0
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `REG_MCU_CONTROL:   reg_rdata <= mcu_control_reg;
        `REG_SOURCE_ENABLE: reg_rdata <= source_enable;
        `REG_FLAGS:         reg_rdata <= {flag_req1, flag_req0,
                                          flag_pc, 5'h00};
        `REG_PCMASK_LO:     reg_rdata <= pin_change_mask[7:0];
        `REG_PCMASK_HI:     reg_rdata <= pin_change_mask[15:8];
        `REG_GLOBAL:        reg_rdata <= {7'h00, global_enable};
        `REG_IRQ_STATUS:    reg_rdata <= irq_status;
        `REG_IRQ_MASK:      reg_rdata <= irq_mask;
        `REG_PIN_STATE_LO:  reg_rdata <= pc_prev[7:0];
        `REG_PIN_STATE_HI:  reg_rdata <= pc_prev[15:8];
        `REG_VECTOR:        reg_rdata <= {any_pending, 2'h0,
                                          best_vector};
        default:            reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // pulse-width needs of the driver are met by sampling every clock
  // pulses shorter than one clock may fall between two samples
  // this net only gathers inputs that have no use in this block
  wire unused_ok = ext_sense_select_hi ^ ext_sense_select_lo ^
                   periph_request[0] ^ periph_request[1] ^
                   periph_request[12] ^ (|mcu_control_reg[7:4]);

endmodule
`default_nettype wire

//--- src/ext_irq_regs.vh
// Purpose: register offsets, field positions, reset values and vectors
//          for the external interrupt and vector map block
// Assumes: 8-bit register port, byte offsets
// Notes:   definitions only
`ifndef EXT_IRQ_REGS_VH
`define EXT_IRQ_REGS_VH

// register offsets
`define REG_MCU_CONTROL    4'h0
`define REG_SOURCE_ENABLE  4'h1
`define REG_FLAGS          4'h2
`define REG_PCMASK_LO      4'h3
`define REG_PCMASK_HI      4'h4
`define REG_GLOBAL         4'h5
`define REG_IRQ_STATUS     4'h6
`define REG_IRQ_MASK       4'h7
`define REG_PIN_STATE_LO   4'h8
`define REG_PIN_STATE_HI   4'h9
`define REG_VECTOR         4'ha

// sense-control encodings
`define SENSE_LOW          2'h0
`define SENSE_ANY          2'h1
`define SENSE_FALL         2'h2
`define SENSE_RISE         2'h3

// mcu control field positions (request 0 in 1:0, request 1 in 3:2)
`define MCR_SENSE0_LO      0
`define MCR_SENSE1_LO      2

// enable / flag bit positions
`define BIT_REQ1           7
`define BIT_REQ0           6
`define BIT_PC_HI          5
`define BIT_PC_LO          4
`define BIT_PCF            5

// reset values
`define RST_MCU_CONTROL    8'h00
`define RST_ENABLE         8'h00
`define RST_PCMASK_LO      8'hc8
`define RST_PCMASK_HI      8'h00
`define RST_IRQ_MASK       8'h00

// vector addresses
`define VEC_RESET          5'h00
`define VEC_REQ0           5'h01
`define VEC_PIN_CHANGE     5'h02
`define VEC_REQ1           5'h0d
`define VEC_LAST           5'h12
`define NUM_SOURCES        18

`endif

//--- src/pin_sync.v
// Purpose: two-flop synchroniser for a group of pins
// Assumes: pins may change at any time relative to clk_sys
// Notes:   first stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 2
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             reset_n,
  // pins in, synchronised out
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] pin_sync_out
);

  reg [WIDTH-1:0] stage1;

  // reset to high: pins idle high so no false edge after reset
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stage1       <= {WIDTH{1'b1}};
      pin_sync_out <= {WIDTH{1'b1}};
    end else begin
      stage1       <= pin_in;
      pin_sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

//--- src/vector_select.v
// Purpose: fixed priority pick of the lowest pending vector
// Assumes: request bit i belongs to vector address i+1
// Notes:   purely combinational
`timescale 1ns/100ps
`default_nettype none

module vector_select #(
  parameter NUM = 18
) (
  // pending requests
  input  wire [NUM-1:0] request,
  // chosen vector
  output reg            any_request,
  output reg  [4:0]     vector_addr
);

  integer i;

  // scan from the top so the lowest index is the last to win
  always @* begin
    any_request = 1'b0;
    vector_addr = 5'h00;
    for (i = NUM - 1; i >= 0; i = i - 1) begin
      if (request[i]) begin
        any_request = 1'b1;
        vector_addr = i[4:0] + 5'h01;
      end
    end
  end

endmodule
`default_nettype wire

//--- test/ext_irq_monitor.sv
// Purpose: port checker for the request and vector block
// Assumes: shadows of the setup registers follow the write strobe
// Notes:   bound to the design at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module ext_irq_monitor #(
  parameter NUM_PC = 16
) (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              reset_n,
  // register port
  input wire logic [3:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_write,
  input wire logic              reg_read,
  input wire logic [7:0]        reg_rdata,
  // pads and core side
  input wire logic              ext_request0_pin,
  input wire logic              ext_request1_pin,
  input wire logic [NUM_PC-1:0] pin_change_inputs,
  input wire logic [17:0]       periph_request,
  input wire logic              io_clock_running,
  input wire logic              core_irq,
  input wire logic [4:0]        core_vector,
  input wire logic [4:0]        reset_vector,
  input wire logic              wake_request
);
  logic [7:0] shadow [0:5];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // shadow copy of registers 0..5 so the checks know the mode
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      shadow <= '{8'h00, 8'h00, 8'h00, 8'hc8, 8'h00, 8'h00};
    else if (reg_write && reg_addr < 4'h6)
      shadow[reg_addr] <= reg_wdata;
  end
  // armed conditions, global enable folded in
  wire lvl0 = shadow[0][1:0] == 2'h0 && shadow[1][6] && shadow[5][0];
  wire fall1 = shadow[0][3:2] == 2'h2 && shadow[1][7] && shadow[5][0];
  wire pc_on = (shadow[1][5] | shadow[1][4]) && shadow[5][0];
  wire [NUM_PC-1:0] pc_mask = {shadow[4], shadow[3]};
  // the edge must reach the core while the i/o clock keeps running
  sequence fall_seen;
    $fell(ext_request1_pin) && fall1 ##0 io_clock_running [*3];
  endsequence
  sequence pc_toggle;
    pc_on && $past(io_clock_running) &&
      |((pin_change_inputs ^ $past(pin_change_inputs)) & pc_mask);
  endsequence
  chk_reset_vec_zero: assert property (
    reset_vector == 5'h00) else $error("reset vector not zero");
  chk_vector_range: assert property (
    core_irq |-> core_vector >= 5'h01 && core_vector <= 5'h12)
    else $error("vector outside the table");
  chk_lowest_first: assert property (
    periph_request[2] |-> core_vector != 5'h00 && core_vector <= 5'h03)
    else $error("a higher vector won");
  chk_global_gate: assert property (
    !shadow[5][0] |-> !core_irq) else $error("request without global");
  chk_level_hold: assert property (
    lvl0 && !ext_request0_pin |-> core_irq && core_vector == 5'h01)
    else $error("low level not held as request");
  chk_level_wake: assert property (
    lvl0 && !ext_request0_pin |-> wake_request)
    else $error("low level gave no wake");
  chk_edge_flag: assert property (
    fall_seen |-> ##[0:3] core_irq) else $error("falling edge lost");
  chk_pc_wake: assert property (
    pc_toggle |-> wake_request) else $error("pin change gave no wake");
  chk_pc_request: assert property (
    pc_toggle |-> ##[0:2] core_irq) else $error("pin change lost");
  chk_rdata_idle: assert property (
    !$past(reg_read) |-> reg_rdata == 8'h00) else $error("stray rdata");
endmodule
bind ext_irq_vector_map ext_irq_monitor #(.NUM_PC(NUM_PC)) mon_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .ext_request0_pin(ext_request0_pin),
  .ext_request1_pin(ext_request1_pin),
  .pin_change_inputs(pin_change_inputs), .periph_request(periph_request),
  .io_clock_running(io_clock_running), .core_irq(core_irq),
  .core_vector(core_vector), .reset_vector(reset_vector),
  .wake_request(wake_request));
`default_nettype wire

//--- test/board_pins.sv
// Purpose: board logic driving the request and pin-change pads
// Assumes: pads change just after a rising clock edge
// Notes:   sel 16 and 17 pick the two request pads
`timescale 1ns/100ps
`default_nettype none
module board_pins (
  // clock
  input  wire logic        clk_sys,
  // pads
  output var  logic        ext_request0_pin,
  output var  logic        ext_request1_pin,
  output var  logic [15:0] pin_change_inputs
);
  // request pads idle high so a low level is never armed by accident
  initial begin
    ext_request0_pin = 1'b1;
    ext_request1_pin = 1'b1;
    pin_change_inputs = 16'h0000;
  end
  // hold each level three clocks; one clock could be missed
  task automatic drive(input int sel, input logic val);
    @(posedge clk_sys);
    if (sel == 16)
      ext_request0_pin <= val;
    else if (sel == 17)
      ext_request1_pin <= val;
    else
      pin_change_inputs[sel] <= val;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// Purpose: self-checking bench for the request and vector block
// Assumes: 40 MHz clock, reset held five cycles
// Notes:   pads come from the board model, the rest from here
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk_sys, reset_n, reg_write, reg_read, core_ack;
  logic        io_clock_running;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, rd;
  logic [17:0] periph_request;
  wire  [7:0]  reg_rdata;
  wire  [15:0] pin_change_inputs;
  wire  [4:0]  core_vector, reset_vector;
  wire         ext_request0_pin, ext_request1_pin;
  wire         core_irq, wake_request, irq;
  int          fails, cmp_count, cycles;
  logic [11:0] rst_tab [6] = '{12'h000, 12'h100, 12'h3c8, 12'h400,
                               12'h700, 12'hf00};
  ext_irq_vector_map #(.NUM_PC(16)) ext_irq_vector_map_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .ext_request0_pin(ext_request0_pin),
    .ext_request1_pin(ext_request1_pin),
    .pin_change_inputs(pin_change_inputs),
    .periph_request(periph_request), .core_ack(core_ack),
    .io_clock_running(io_clock_running), .core_irq(core_irq),
    .core_vector(core_vector), .reset_vector(reset_vector),
    .wake_request(wake_request), .irq(irq));
  board_pins board_pins_i (.clk_sys(clk_sys),
    .ext_request0_pin(ext_request0_pin),
    .ext_request1_pin(ext_request1_pin),
    .pin_change_inputs(pin_change_inputs));
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // cut a hang short, well above the roughly 160 cycles needed
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      tally_and_finish;
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    rd = reg_rdata;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic settle;
    @(negedge clk_sys);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    {reset_n, reg_write, reg_read, core_ack} = 4'h0;
    {reg_addr, reg_wdata, periph_request} = 30'h0;
    io_clock_running = 1'b1;
    fails = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    // reset values, unmapped read last
    foreach (rst_tab[i]) begin
      rd_reg(rst_tab[i][11:8]);
      check(rd, rst_tab[i][7:0]);
    end
    check(reset_vector, 8'h00);
    // each peripheral source alone lands on its own vector
    wr(4'h5, 8'h01);
    for (int i = 2; i < 18; i++) begin
      if (i == 12)
        continue;
      @(posedge clk_sys);
      periph_request <= 18'h1 << i;
      settle;
      check(core_vector, 8'(i + 1));
    end
    @(posedge clk_sys);
    periph_request <= 18'h08100;
    settle;
    check(core_vector, 8'h09);
    rd_reg(4'ha);
    check(rd, 8'h89);
    @(posedge clk_sys);
    periph_request <= 18'h20004;
    settle;
    check(core_vector, 8'h03);
    wr(4'h5, 8'h00);
    settle;
    check(core_irq, 1'b0);
    @(posedge clk_sys);
    periph_request <= 18'h0;
    // low level on request 0 holds, and wakes with the clock stopped
    wr(4'h5, 8'h01);
    wr(4'h1, 8'h40);
    io_clock_running <= 1'b0;
    board_pins_i.drive(16, 1'b0);
    settle;
    check(wake_request, 1'b1);
    repeat (4) begin
      settle;
      check(core_vector, 8'h01);
    end
    board_pins_i.drive(16, 1'b1);
    io_clock_running <= 1'b1;
    settle;
    check(core_irq, 1'b0);
    // every edge code on request 1, both edges, flag cleared between
    wr(4'h1, 8'h80);
    for (int m = 1; m < 4; m++) begin
      wr(4'h0, 8'(m << 2));
      wr(4'h2, 8'hc0);
      board_pins_i.drive(17, 1'b0);
      rd_reg(4'h2);
      check(rd, (m != 3) ? 8'h80 : 8'h00);
      wr(4'h2, 8'hc0);
      board_pins_i.drive(17, 1'b1);
      rd_reg(4'h2);
      check(rd, (m != 2) ? 8'h80 : 8'h00);
    end
    settle;
    check(core_vector, 8'h0d);
    @(posedge clk_sys);
    core_ack <= 1'b1;
    @(posedge clk_sys);
    core_ack <= 1'b0;
    settle;
    check(core_irq, 1'b0);
    // edges while the i/o clock is halted are not seen
    wr(4'h0, 8'h08);
    io_clock_running <= 1'b0;
    board_pins_i.drive(17, 1'b0);
    io_clock_running <= 1'b1;
    rd_reg(4'h2);
    check(rd, 8'h00);
    board_pins_i.drive(17, 1'b1);
    rd_reg(4'h2);
    check(rd, 8'h00);
    // pin change: masked top pin flags, unmasked pin does not
    wr(4'h1, 8'h10);
    wr(4'h3, 8'h01);
    wr(4'h4, 8'h80);
    board_pins_i.drive(15, 1'b1);
    settle;
    check(core_vector, 8'h02);
    wr(4'h2, 8'h20);
    board_pins_i.drive(1, 1'b1);
    rd_reg(4'h2);
    check(rd, 8'h00);
    rd_reg(4'h8);
    check(rd, 8'h02);
    rd_reg(4'h9);
    check(rd, 8'h80);
    // status, mask and the level interrupt line
    wr(4'h6, 8'h0f);
    board_pins_i.drive(0, 1'b1);
    rd_reg(4'h6);
    check(rd, 8'h04);
    check(irq, 1'b0);
    wr(4'h7, 8'h04);
    settle;
    check(irq, 1'b1);
    wr(4'h6, 8'h04);
    settle;
    check(irq, 1'b0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
